/* File: design/pei_regs.svh */
// peripheral event interconnect: power-mode codes and route permission masks
// assumes the includer uses the mode code at the width of the mode port
`ifndef PEI_REGS_SVH
`define PEI_REGS_SVH
`define PEI_MODE_RUN       3'h0
`define PEI_MODE_SLEEP     3'h1
`define PEI_MODE_LP_RUN    3'h2
`define PEI_MODE_LP_SLEEP  3'h3
`define PEI_MODE_STOP      3'h4
// permission masks, bit index = mode code
`define PEI_ALLOW_NO_STOP  5'h0f
`define PEI_ALLOW_ALL      5'h1f
`define PEI_ALLOW_RUN_SLP  5'h03
`endif

/* File: design/pei_pkg.sv */
// peripheral event interconnect: shared types
// assumes nothing of its surroundings
package pei_pkg;
  typedef logic [2:0] pei_mode_t;   // power mode code
  typedef logic [4:0] pei_allow_t;  // one bit per mode
endpackage

/* File: design/pei_sync_if.sv */
// pei_sync_if: carries one event between the matrix and a synchroniser
// assumes both ends share the destination clock
`timescale 1ns/100ps
interface pei_sync_if;
  logic ev_in;   // gated source level
  logic pulse;   // one-cycle destination trigger
  modport src (output ev_in, input pulse);
  modport dst (input ev_in, output pulse);
endinterface

/* File: design/pei_sync.sv */
// pei_sync: two-flop synchroniser plus rising-edge pulse for one route
// assumes clock is the destination peripheral clock
`timescale 1ns/100ps
module pei_sync (
  input wire logic clock,
  input wire logic rst_n,
  pei_sync_if.dst  link
);
  logic meta;       // first stage, read only by stage two
  logic stable;     // second stage
  logic prev;       // previous stable value
  logic next_meta;
  logic next_stable;
  logic next_prev;

  // next values of the synchroniser chain
  always_comb begin
    next_meta   = link.ev_in;
    next_stable = meta;
    next_prev   = stable;
  end

  // register the chain
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta   <= 1'b0;
      stable <= 1'b0;
      prev   <= 1'b0;
    end else begin
      meta   <= next_meta;
      stable <= next_stable;
      prev   <= next_prev;
    end
  end

  // one pulse per rising edge of the synchronised level
  assign link.pulse = stable & ~prev;

  // a pulse is never two cycles long
  single_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
    link.pulse |=> !link.pulse) else $error("trigger longer than one cycle");
endmodule

/* File: design/pei_matrix.sv */
// pei_matrix: fixed event routes between peripherals, gated by power mode
// assumes all sources are levels on clock; each destination trigger is a pulse
// Notes on behaviour
// - events travel on fixed hardware paths
// - each route gated by its permitted modes
// - timer to timer blocked in stop
// - wakeup event to small timer, not stop
// - clock events to low-power timer always
// - oscillator as timer input, not stop
// - start-of-frame to recovery unit and timer, run/sleep
// - pins to timers not stop; low-power timer always
`timescale 1ns/100ps
`include "pei_regs.svh"
module pei_matrix
  import pei_pkg::*;
#(
  parameter int NUM_PINS = 2   // pin event inputs
) (
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [2:0]          power_mode,
  input  wire logic                analog_comparator_output,
  input  wire logic                any_timer_trgo,
  input  wire logic                rtc_wakeup,
  input  wire logic                rtc_event,
  input  wire logic                osc_clock_level,
  input  wire logic                usb_sof,
  input  wire logic [NUM_PINS-1:0] pin_event,
  output logic                     general_timer_a_trig,
  output logic                     small_timer_b_trig,
  output logic                     small_timer_c_trig,
  output logic                     general_timer_d_trig,
  output logic                     low_power_timer_trig,
  output logic                     clock_recovery_unit_sync,
  output logic                     internal_48mhz_oscillator_trim,
  output logic                     converter_trig
);
  localparam int NR = 9;  // number of routes
  localparam int ND = 8;  // number of destination triggers

  // refuse a pin count that leaves the pin routes without a source
  if (NUM_PINS < 1) begin : g_bad_pins
    $error("need at least one pin");
  end

  // route index map
  localparam int R_CMP_TIM = 0;
  localparam int R_CMP_LP  = 1;
  localparam int R_TIM_TIM = 2;
  localparam int R_RTC_B   = 3;
  localparam int R_RTC_LP  = 4;
  localparam int R_OSC_TIM = 5;
  localparam int R_SOF     = 6;
  localparam int R_PIN_TIM = 7;
  localparam int R_PIN_LP  = 8;

  // destination index map
  localparam int D_A    = 0;  // general timer a
  localparam int D_B    = 1;  // small timer b
  localparam int D_C    = 2;  // small timer c
  localparam int D_D    = 3;  // general timer d
  localparam int D_LP   = 4;  // low-power timer
  localparam int D_CRU  = 5;  // clock recovery unit
  localparam int D_TRIM = 6;  // oscillator trim
  localparam int D_CONV = 7;  // converter trigger

  logic [NR-1:0] src;     // raw source per route
  logic [NR-1:0] gated;   // source after mode gate
  logic [NR-1:0] trig;    // synchronised pulses
  pei_allow_t    allow [NR];
  logic          pin_any;
  pei_allow_t    mode_hot;  // one-hot of the current mode, zero if unknown

  assign pin_any = |pin_event;

  // fixed sources per route
  always_comb begin
    src            = '0;
    src[R_CMP_TIM] = analog_comparator_output;
    src[R_CMP_LP]  = analog_comparator_output;
    src[R_TIM_TIM] = any_timer_trgo;
    src[R_RTC_B]   = rtc_wakeup;
    src[R_RTC_LP]  = rtc_event;
    src[R_OSC_TIM] = osc_clock_level;
    src[R_SOF]     = usb_sof;
    src[R_PIN_TIM] = pin_any;
    src[R_PIN_LP]  = pin_any;
  end

  // fixed permission masks
  always_comb begin
    allow[R_CMP_TIM] = `PEI_ALLOW_NO_STOP;
    allow[R_CMP_LP]  = `PEI_ALLOW_ALL;
    allow[R_TIM_TIM] = `PEI_ALLOW_NO_STOP;
    allow[R_RTC_B]   = `PEI_ALLOW_NO_STOP;
    allow[R_RTC_LP]  = `PEI_ALLOW_ALL;
    allow[R_OSC_TIM] = `PEI_ALLOW_NO_STOP;
    allow[R_SOF]     = `PEI_ALLOW_RUN_SLP;
    allow[R_PIN_TIM] = `PEI_ALLOW_NO_STOP;
    allow[R_PIN_LP]  = `PEI_ALLOW_ALL;
  end

  // decode the mode code; the mask is never indexed past its width
  always_comb begin
    mode_hot = '0;
    case (power_mode)
      `PEI_MODE_RUN:      mode_hot[`PEI_MODE_RUN]      = 1'b1;
      `PEI_MODE_SLEEP:    mode_hot[`PEI_MODE_SLEEP]    = 1'b1;
      `PEI_MODE_LP_RUN:   mode_hot[`PEI_MODE_LP_RUN]   = 1'b1;
      `PEI_MODE_LP_SLEEP: mode_hot[`PEI_MODE_LP_SLEEP] = 1'b1;
      `PEI_MODE_STOP:     mode_hot[`PEI_MODE_STOP]     = 1'b1;
      default:            mode_hot = '0; // unknown codes block every route
    endcase
  end

  // one gate and one synchroniser per route
  for (genvar r = 0; r < NR; r++) begin : g_route
    pei_sync_if link ();
    logic mode_ok;
    // the route passes only in a mode that its mask permits
    assign mode_ok = |(allow[r] & mode_hot);
    assign gated[r] = src[r] & mode_ok;
    assign link.ev_in = gated[r];
    assign trig[r] = link.pulse;
    pei_sync u_sync (
      .clock (clock),
      .rst_n (rst_n),
      .link  (link)
    );
  end

  logic [ND-1:0] next_out; // next destination triggers
  logic [ND-1:0] out_q;    // registered destination triggers

  // destination fan-in
  always_comb begin
    next_out    = '0;
    next_out[D_A]    = trig[R_CMP_TIM] | trig[R_TIM_TIM] | trig[R_OSC_TIM] | trig[R_PIN_TIM];
    next_out[D_B]    = trig[R_CMP_TIM] | trig[R_TIM_TIM] | trig[R_RTC_B] | trig[R_OSC_TIM] | trig[R_PIN_TIM];
    next_out[D_C]    = trig[R_CMP_TIM] | trig[R_TIM_TIM] | trig[R_OSC_TIM] | trig[R_PIN_TIM];
    next_out[D_D]    = trig[R_TIM_TIM] | trig[R_SOF] | trig[R_OSC_TIM] | trig[R_PIN_TIM];
    next_out[D_LP]   = trig[R_CMP_LP] | trig[R_RTC_LP] | trig[R_PIN_LP];
    next_out[D_CRU]  = trig[R_SOF];
    next_out[D_TRIM] = trig[R_SOF];
    next_out[D_CONV] = trig[R_PIN_TIM];
  end

  // register outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_q <= '0;
    end else begin
      out_q <= next_out;
    end
  end

  assign general_timer_a_trig           = out_q[D_A];
  assign small_timer_b_trig             = out_q[D_B];
  assign small_timer_c_trig             = out_q[D_C];
  assign general_timer_d_trig           = out_q[D_D];
  assign low_power_timer_trig           = out_q[D_LP];
  assign clock_recovery_unit_sync       = out_q[D_CRU];
  assign internal_48mhz_oscillator_trim = out_q[D_TRIM];
  assign converter_trig                 = out_q[D_CONV];

  // in stop, held for the pipeline, no timer-to-timer pulse comes
  stop_blocks_tim_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode == `PEI_MODE_STOP) [*4] |-> !trig[R_TIM_TIM]) else $error("timer route active in stop");

  // outside run and sleep the start-of-frame route stays quiet
  stop_blocks_sof_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode >= `PEI_MODE_LP_RUN) [*4] |-> !trig[R_SOF]) else $error("sof route active outside run");

  // in stop the wakeup route to the small timer stays quiet
  stop_blocks_wake_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode == `PEI_MODE_STOP) [*4] |-> !trig[R_RTC_B]) else $error("wakeup route active in stop");

  // an unknown mode code, held for the pipeline, silences every route
  bad_mode_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode > `PEI_MODE_STOP) [*4] |-> trig == '0) else $error("route active in unknown mode");

  // the wakeup trigger reaches the small timer on the next cycle
  rtc_wake_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig[R_RTC_B] |=> small_timer_b_trig) else $error("wakeup trigger lost");

  // a permitted wakeup edge reaches the small timer three cycles on
  wake_run_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(rtc_wakeup) && power_mode < `PEI_MODE_STOP) |=> ##2 small_timer_b_trig)
    else $error("wakeup edge lost");

  // a clock event edge reaches the low-power timer in every known mode
  lp_rtc_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(rtc_event) && power_mode <= `PEI_MODE_STOP) |=> ##2 low_power_timer_trig)
    else $error("rtc to lp timer lost");

  // a pin edge in stop still reaches the low-power timer
  pin_lp_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode == `PEI_MODE_STOP && !pin_any) ##1 (power_mode == `PEI_MODE_STOP && pin_any)
    |=> ##2 low_power_timer_trig) else $error("pin to lp timer lost in stop");

  // a pin edge outside stop reaches small timer c and the converter
  pin_run_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(pin_any) && power_mode < `PEI_MODE_STOP) |=> ##2 (small_timer_c_trig && converter_trig))
    else $error("pin edge lost");

  // in stop neither the oscillator nor the pin timer route fires
  osc_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    (power_mode == `PEI_MODE_STOP) [*4] |-> !trig[R_OSC_TIM] && !trig[R_PIN_TIM]) else $error("osc route in stop");

  // an oscillator edge outside stop reaches a timer input
  osc_run_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(osc_clock_level) && power_mode < `PEI_MODE_STOP) |=> ##2 general_timer_d_trig)
    else $error("oscillator edge lost");

  // a timer edge outside stop triggers another timer
  timer_run_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(any_timer_trgo) && power_mode < `PEI_MODE_STOP) |=> ##2 general_timer_a_trig)
    else $error("timer edge lost");

  // the start-of-frame gate opens only in run or sleep
  gate_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
    gated[R_SOF] |-> power_mode <= `PEI_MODE_SLEEP) else $error("sof gate wrong");

  // a start-of-frame edge in run or sleep reaches the recovery unit
  sof_run_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    ($rose(usb_sof) && power_mode <= `PEI_MODE_SLEEP) |=> ##2 clock_recovery_unit_sync)
    else $error("sof edge lost");

  // the start-of-frame trigger also reaches the trim and the timer
  sof_timer_path_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig[R_SOF] |=> general_timer_d_trig && internal_48mhz_oscillator_trim) else $error("sof timer lost");

  // the output stage adds exactly one cycle
  fixed_latency_a: assert property (@(posedge clock) disable iff (!rst_n)
    trig[R_SOF] |=> clock_recovery_unit_sync) else $error("sof latency not fixed");
endmodule

/* File: verif/pei_src_model.sv */
// pei_src_model: peripheral event sources feeding the interconnect
// assumes fire is driven on clock; each fired line gives one short level
`timescale 1ns/100ps
module pei_src_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] fire,
  output logic      [7:0] level
);
  logic [7:0] next_level; // level for the coming cycle
  // a fired line goes high for one cycle, then low for at least one
  always_comb begin
    next_level = fire & ~level;
  end
  // register the source levels, quiet in reset
  always_ff @(posedge clock) begin
    level <= rst_n ? next_level : 8'h00;
  end
endmodule

/* File: verif/peripheral_event_interconnect_tb.sv */
// bench: random source events and power modes, outputs against a route model
// assumes the interconnect pulses each destination three cycles after an edge
`timescale 1ns/100ps
module peripheral_event_interconnect_tb;
  logic        clock = 1'b0;      // 40 MHz clock
  logic        rst_n = 1'b0;      // sync reset, active low
  logic [2:0]  power_mode = 3'h0; // current mode code
  logic [7:0]  fire = 8'h00;      // source requests
  logic [7:0]  lv;                // source levels
  logic [7:0]  outs;              // design triggers
  logic [8:0]  prev = 9'h000;     // model gated level per route, last cycle
  logic [7:0]  pend [$] = {8'h00, 8'h00, 8'h00}; // expected pulses, oldest first
  logic [31:0] seed = 32'h2e98;   // random state
  bit          live = 1'b0;       // set once outputs are defined
  int          failures = 0;
  int          num_checks = 0;
  always #12.5 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // gated level per route: pin lp, pin tim, sof, osc, rtc event, wake, timer, cmp lp, cmp tim
  function automatic logic [8:0] gate(input logic [2:0] m, input logic [7:0] s);
    logic ns;
    logic al;
    logic rs;
    logic pin;
    ns = m < 3'h4;
    al = m < 3'h5;
    rs = m < 3'h2;
    pin = |s[7:6];
    return {pin & al, pin & ns, s[5] & rs, s[4] & ns, s[3] & al, s[2] & ns, s[1] & ns, s[0] & al, s[0] & ns};
  endfunction
  // each route has its own edge; destinations OR them: conv, trim, cru, lp, d, c, b, a
  function automatic logic [7:0] fan(input logic [8:0] e);
    logic a;
    a = e[0] | e[2] | e[5] | e[7];
    return {e[7], e[6], e[6], e[1] | e[4] | e[8], e[2] | e[5] | e[6] | e[7], a, a | e[3], a};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value triggers expected %h seen %h", exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  pei_src_model src (.clock(clock), .rst_n(rst_n), .fire(fire), .level(lv));
  pei_matrix #(.NUM_PINS(2)) uut (
    .clock(clock), .rst_n(rst_n), .power_mode(power_mode),
    .analog_comparator_output(lv[0]), .any_timer_trgo(lv[1]), .rtc_wakeup(lv[2]),
    .rtc_event(lv[3]), .osc_clock_level(lv[4]), .usb_sof(lv[5]), .pin_event(lv[7:6]),
    .general_timer_a_trig(outs[0]), .small_timer_b_trig(outs[1]), .small_timer_c_trig(outs[2]),
    .general_timer_d_trig(outs[3]), .low_power_timer_trig(outs[4]),
    .clock_recovery_unit_sync(outs[5]), .internal_48mhz_oscillator_trim(outs[6]),
    .converter_trig(outs[7])
  );
  // random stimulus: sparse source events, occasional mode change
  always @(posedge clock) begin
    seed <= lfsr(seed);
    fire <= seed[7:0] & seed[15:8];
    if (seed[20:17] == 4'h0) power_mode <= seed[26:24];
  end
  // route model: rising edge of each gated route level, three entries of pipeline
  always @(posedge clock) begin
    live <= 1'b1;
    prev <= rst_n ? gate(power_mode, lv) : 9'h000;
    if (rst_n) begin
      pend.push_back(fan(gate(power_mode, lv) & ~prev));
      void'(pend.pop_front());
    end else begin
      pend = {8'h00, 8'h00, 8'h00};
    end
  end
  // compare once the edge's updates have settled
  always @(negedge clock) begin
    if (live) check(outs, pend[0]);
  end
  // main sequence with a reset in mid-run
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4000) @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4000) @(posedge clock);
    conclude();
  end
  // watchdog well past the expected run length
  initial begin
    #(25 * 10000);
    failures++;
    conclude();
  end
endmodule
